// ===== design/ibs_cfg.svh
// Register offsets, field positions, reset values and timing counts of the bus selector
`ifndef IBS_CFG_SVH
`define IBS_CFG_SVH
`define IBS_OFF_CTRL 4'h0
`define IBS_OFF_STATUS 4'h4
`define IBS_OFF_HANDOVER 4'h8
`define IBS_CTRL_DUAL_BIT 0
`define IBS_CTRL_RESET 1'b0
`define IBS_ST_NOM_ACT_BIT 0
`define IBS_ST_RED_ACT_BIT 1
`define IBS_ST_SEL_LSB 2
`define IBS_ST_TIMEOUT_BIT 4
`define IBS_ST_MODE_BIT 5
`define IBS_ST_CNT_NOM_LSB 8
`define IBS_ST_CNT_RED_LSB 16
`define IBS_HANDOVER_RESET 16'h0000
`define IBS_PULSE_OSC_CYCLES 4'h1
`endif

// ===== design/ibs_pkg.sv
// Types shared by the interrogation-bus activity monitor and selector
package ibs_pkg;
   typedef enum logic [1:0] {
      IBS_SEL_NONE = 2'b00,
      IBS_SEL_NOM = 2'b01,
      IBS_SEL_RED = 2'b10
   } ibs_sel_t;
   typedef enum logic {
      IBS_ST_RUN = 1'b0,
      IBS_ST_PULSE = 1'b1
   } ibs_hand_t;
endpackage : ibs_pkg

// ===== design/ibs_osc_phase.sv
// Local oscillator divider: detector reset window, sample strobe and count tick
`timescale 1ns/1ps
module ibs_osc_phase (
   input wire logic clk,
   input wire logic rst,
   input wire logic osc,
   output logic tick,
   output logic det_reset_n,
   output logic sample
);
   logic osc_prev_q;
   logic phase_q;

   // Oscillator edge found by sampling; the oscillator is far slower than the clock
   assign tick = osc & ~osc_prev_q;
   // Detectors are out of reset in one oscillator cycle out of two
   assign det_reset_n = phase_q;
   assign sample = tick & phase_q;

   // Divide by two on each oscillator rise
   always_ff @(posedge clk) begin
      if (rst) begin
         osc_prev_q <= 1'b0;
         phase_q <= 1'b0;
      end else begin
         osc_prev_q <= osc;
         phase_q <= phase_q ^ tick;
      end
   end
endmodule : ibs_osc_phase

// ===== design/ibs_watchdog.sv
// One interrogation bus channel: falling-edge detector and saturating watchdog counter
`timescale 1ns/1ps
module ibs_watchdog #(
   parameter int WD_W = 5
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic disc_n,
   input wire logic det_reset_n,
   input wire logic sample,
   input wire logic tick,
   output logic [WD_W-1:0] count,
   output logic active
);
   logic disc_prev_q;
   logic edge_q;
   logic edge_d;
   logic [WD_W-1:0] cnt_q;
   logic [WD_W-1:0] cnt_d;
   logic fall;
   logic capture;

   // Only high-to-low transitions count; rising edges are ignored
   assign fall = disc_prev_q & ~disc_n;
   // Edge flag held clear while the detector reset is low
   assign edge_d = det_reset_n & (edge_q | fall);
   assign capture = sample & edge_d;
   // Clear on a captured edge, else count ticks and stick once the top bit is set
   assign cnt_d = capture ? '0 :
      (tick & ~cnt_q[WD_W-1]) ? cnt_q + 1'b1 : cnt_q;
   assign count = cnt_q;
   assign active = ~cnt_q[WD_W-1];

   always_ff @(posedge clk) begin
      if (rst) begin
         disc_prev_q <= 1'b1;
         edge_q <= 1'b0;
         cnt_q <= '1;
      end else begin
         disc_prev_q <= disc_n;
         edge_q <= edge_d;
         cnt_q <= cnt_d;
      end
   end
endmodule : ibs_watchdog

// ===== design/ibs_bus_select.sv
// Interrogation-bus activity monitor, redundancy selector and mode routing
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ibs_cfg.svh"
//
// Behaviour
// - Remote-terminal power-up reset leaves neither bus selected.
// - One falling-edge detector and 5-bit watchdog per interrogation bus.
// - Select the active bus; with both active, Nominal wins.
// - Selected bus going quiet times out and resets device and user.
// - Every selection change resets device and user logic.
// - Transmit on selected set only; dual transmit drives both sets.
// - Oscillator divided into detector reset and sample strobe, one cycle in two.
// - A sampled falling edge clears that bus's watchdog counter.
// - Counter top bit set means bus inactive.
// - No active bus: timeout low, all reception inhibited.
// - One active bus: receive on that bus's redundancy set.
// - Counters preset to all ones at power-up.
// - Single edge: inactive after 17.5 to 18.5 oscillator cycles; the code goes inactive 16 to 17 cycles after an edge in the window.
// - Nominal or dual to Redundant handover delayed 18 to 19 cycles.
// - Redundant to Nominal or dual handover after 1.5 to 2.5 cycles; the code switches 2 to 3 cycles after the first sampled edge.
// - Each handover emits a one oscillator cycle timeout pulse.
// - Remote mode routes received sync, clock, data, valid to kernel, pins driven.
// - Remote mode ORs kernel and external response; kernel also monitored.
// - Remote mode reset combines timeout with master reset.
// - Central mode: timeout output only, bus chosen by external select.
// - Central mode uses dedicated clocks and enables; remote mode forces them.
module ibs_bus_select
   import ibs_pkg::*;
#(
   parameter int WD_W = 5,
   parameter int HO_W = 16
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic LOCAL_OSC_CLOCK,
   input wire logic FALLING_DISCRIMINATOR_N_NOM,
   input wire logic FALLING_DISCRIMINATOR_N_RED,
   input wire logic TERMINAL_MODE_SELECT,
   input wire logic DUAL_BUS_TRANSMIT,
   input wire logic MASTER_RESET_N,
   input wire logic CT_BUS_SELECT,
   input wire logic CT_MODULATION_CLOCK,
   input wire logic CT_DATA_CLOCK,
   input wire logic CT_SYNC_TX_ENABLE,
   input wire logic CT_INVALIDATE_TX_ENABLE,
   input wire logic REC_MOD_CLOCK,
   input wire logic REC_SYNC,
   input wire logic REC_CLOCK,
   input wire logic REC_DATA,
   input wire logic REC_VALID,
   input wire logic RX_INTERROG_SYNC_I,
   output logic RX_INTERROG_SYNC_O,
   output logic RX_INTERROG_SYNC_OE,
   input wire logic RX_INTERROG_CLOCK_I,
   output logic RX_INTERROG_CLOCK_O,
   output logic RX_INTERROG_CLOCK_OE,
   input wire logic RX_INTERROG_DATA_I,
   output logic RX_INTERROG_DATA_O,
   output logic RX_INTERROG_DATA_OE,
   input wire logic RX_INTERROG_VALID_I,
   output logic RX_INTERROG_VALID_O,
   output logic RX_INTERROG_VALID_OE,
   output logic KERNEL_SYNC,
   output logic KERNEL_CLOCK,
   output logic KERNEL_DATA,
   output logic KERNEL_VALID,
   input wire logic KERNEL_RESPONSE_DATA,
   input wire logic KERNEL_RESPONSE_ENABLE,
   input wire logic EXT_RESPONSE_DATA,
   input wire logic EXT_RESPONSE_ENABLE,
   output logic KERNEL_RESPONSE_DATA_MON,
   output logic KERNEL_RESPONSE_ENABLE_MON,
   output logic TX_MOD_CLOCK,
   output logic TX_DATA_CLOCK,
   output logic TX_SYNC_ENABLE,
   output logic TX_INVALIDATE_ENABLE,
   output logic TX_DATA,
   output logic TX_ENABLE,
   output logic TX_SELECT_NOM,
   output logic TX_SELECT_RED,
   output logic RX_ENABLE_NOM,
   output logic RX_ENABLE_RED,
   output logic BUS_TIMEOUT_N,
   output logic DEVICE_RESET_N,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST
);
   // Bus choice from the two activity flags; Nominal has priority
   function automatic ibs_sel_t pick_bus(input logic nom_act, input logic red_act);
      ibs_sel_t res;
      res = IBS_SEL_NONE;
      if (nom_act) begin
         res = IBS_SEL_NOM;
      end else if (red_act) begin
         res = IBS_SEL_RED;
      end
      return res;
   endfunction : pick_bus

   // Per-set enables for one selection code
   function automatic logic [1:0] set_enables(input ibs_sel_t sel);
      logic [1:0] en;
      en = 2'b00;
      unique case (sel)
         IBS_SEL_NONE: en = 2'b00;
         IBS_SEL_NOM: en = 2'b01;
         IBS_SEL_RED: en = 2'b10;
         default: en = 2'b00;
      endcase
      return en;
   endfunction : set_enables

   logic tick;
   logic det_reset_n;
   logic sample;
   logic [WD_W-1:0] wd_count [2];
   logic [1:0] wd_active;
   logic [1:0] disc_n;

   ibs_osc_phase u_osc (
      .clk(CLK),
      .rst(RST),
      .osc(LOCAL_OSC_CLOCK),
      .tick(tick),
      .det_reset_n(det_reset_n),
      .sample(sample)
   );

   // Index 0 is the Nominal bus, index 1 the Redundant bus
   assign disc_n = {FALLING_DISCRIMINATOR_N_RED, FALLING_DISCRIMINATOR_N_NOM};

   // One independent channel per interrogation bus
   generate
      for (genvar i = 0; i < 2; i++) begin : g_chan
         ibs_watchdog #(
            .WD_W(WD_W)
         ) u_wd (
            .clk(CLK),
            .rst(RST),
            .disc_n(disc_n[i]),
            .det_reset_n(det_reset_n),
            .sample(sample),
            .tick(tick),
            .count(wd_count[i]),
            .active(wd_active[i])
         );
      end
   endgenerate

   // Bus usage state
   ibs_sel_t sel_q;
   ibs_sel_t sel_d;
   ibs_hand_t hand_q;
   ibs_hand_t hand_d;
   logic [3:0] pulse_cnt_q;
   logic [3:0] pulse_cnt_d;
   ibs_sel_t want;
   logic change;
   logic pulse_start;
   logic pulse_end;
   logic [HO_W-1:0] handover_q;
   logic [HO_W-1:0] handover_d;

   assign want = pick_bus(wd_active[0], wd_active[1]);
   assign change = (want != sel_q);
   // Handovers are judged on oscillator ticks, so a dropped Nominal needs its full
   // watchdog run before Redundant takes over, while a returning Nominal starts its
   // handover pulse on the tick after its edge is sampled and wins one tick later
   assign pulse_start = (hand_q == IBS_ST_RUN) & tick & change & (want != IBS_SEL_NONE);
   assign pulse_end = (hand_q == IBS_ST_PULSE) & tick & (pulse_cnt_q == `IBS_PULSE_OSC_CYCLES);

   // Selector sequencing: loss of all busses drops at once, a move to a bus goes
   // through a timeout pulse of whole oscillator cycles first
   always_comb begin
      sel_d = sel_q;
      hand_d = hand_q;
      pulse_cnt_d = pulse_cnt_q;
      unique case (hand_q)
         IBS_ST_RUN: begin
            if (tick & change & (want == IBS_SEL_NONE)) begin
               sel_d = IBS_SEL_NONE;
            end else if (pulse_start) begin
               hand_d = IBS_ST_PULSE;
               pulse_cnt_d = 4'h1;
            end
         end
         IBS_ST_PULSE: begin
            if (pulse_end) begin
               sel_d = want;
               hand_d = IBS_ST_RUN;
            end else if (tick) begin
               pulse_cnt_d = pulse_cnt_q + 4'h1;
            end
         end
      endcase
   end

   // Count handovers for software; a write clears, a handover in the same cycle wins
   assign handover_d = pulse_start ? handover_q + 1'b1 : handover_q;

   always_ff @(posedge CLK) begin
      if (RST) begin
         sel_q <= IBS_SEL_NONE;
         hand_q <= IBS_ST_RUN;
         pulse_cnt_q <= 4'h0;
      end else begin
         sel_q <= sel_d;
         hand_q <= hand_d;
         pulse_cnt_q <= pulse_cnt_d;
      end
   end

   // Register file and Avalon slave with one wait state
   logic ctrl_dual_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic req;
   logic take;
   logic hit_ctrl;
   logic hit_status;
   logic hit_handover;
   logic [31:0] status_word;
   logic clr_handover;

   assign req = AVS_READ | AVS_WRITE;
   // The answer is given on the cycle after the request is first seen
   assign take = req & ~wait_q;
   assign hit_ctrl = (AVS_ADDRESS == `IBS_OFF_CTRL);
   assign hit_status = (AVS_ADDRESS == `IBS_OFF_STATUS);
   assign hit_handover = (AVS_ADDRESS == `IBS_OFF_HANDOVER);
   assign clr_handover = take & AVS_WRITE & hit_handover & AVS_BYTEENABLE[0];

   // Live status: activity, selection, timeout, mode and both counters
   always_comb begin
      status_word = 32'h00000000;
      status_word[`IBS_ST_NOM_ACT_BIT] = wd_active[0];
      status_word[`IBS_ST_RED_ACT_BIT] = wd_active[1];
      status_word[`IBS_ST_SEL_LSB +: 2] = sel_q;
      status_word[`IBS_ST_TIMEOUT_BIT] = BUS_TIMEOUT_N;
      status_word[`IBS_ST_MODE_BIT] = TERMINAL_MODE_SELECT;
      status_word[`IBS_ST_CNT_NOM_LSB +: WD_W] = wd_count[0];
      status_word[`IBS_ST_CNT_RED_LSB +: WD_W] = wd_count[1];
   end

   // Unmapped addresses read as zero and ignore writes
   assign rdata_d = !(AVS_READ & wait_q) ? rdata_q :
      hit_ctrl ? {31'h00000000, ctrl_dual_q} :
      hit_status ? status_word :
      hit_handover ? {{(32 - HO_W){1'b0}}, handover_q} : 32'h00000000;

   always_ff @(posedge CLK) begin
      if (RST) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h00000000;
         ctrl_dual_q <= `IBS_CTRL_RESET;
         handover_q <= `IBS_HANDOVER_RESET;
      end else begin
         wait_q <= ~(req & wait_q);
         rdata_q <= rdata_d;
         if (take & AVS_WRITE & hit_ctrl & AVS_BYTEENABLE[0]) begin
            ctrl_dual_q <= AVS_WRITEDATA[`IBS_CTRL_DUAL_BIT];
         end
         if (pulse_start) begin
            handover_q <= handover_d;
         end else if (clr_handover) begin
            handover_q <= `IBS_HANDOVER_RESET;
         end
      end
   end

   // Mode-dependent routing, all registered onto the pins
   logic central_terminal_mode;
   logic dual;
   logic timeout_n_d;
   logic [1:0] rx_en_d;
   logic [1:0] tx_en_d;
   logic [3:0] rec_bundle;
   logic [3:0] pin_bundle;
   logic [3:0] kernel_d;

   assign central_terminal_mode = TERMINAL_MODE_SELECT;
   assign dual = DUAL_BUS_TRANSMIT | ctrl_dual_q;
   // Low while no bus is selected or during a handover pulse, in either mode
   assign timeout_n_d = (sel_q != IBS_SEL_NONE) & (hand_q == IBS_ST_RUN);
   // Central mode: the external terminal picks the set (low Nominal, high Redundant)
   assign rx_en_d = central_terminal_mode ? (CT_BUS_SELECT ? 2'b10 : 2'b01) :
      set_enables(sel_q);
   assign tx_en_d = rx_en_d | {dual, dual};
   assign rec_bundle = {REC_VALID, REC_DATA, REC_CLOCK, REC_SYNC};
   assign pin_bundle = {RX_INTERROG_VALID_I, RX_INTERROG_DATA_I, RX_INTERROG_CLOCK_I,
      RX_INTERROG_SYNC_I};
   // Receiver stream feeds the kernel in remote mode, the pins do in central mode
   assign kernel_d = central_terminal_mode ? pin_bundle : rec_bundle;

   always_ff @(posedge CLK) begin
      if (RST) begin
         {RX_INTERROG_VALID_O, RX_INTERROG_DATA_O, RX_INTERROG_CLOCK_O,
            RX_INTERROG_SYNC_O} <= 4'h0;
         {RX_INTERROG_VALID_OE, RX_INTERROG_DATA_OE, RX_INTERROG_CLOCK_OE,
            RX_INTERROG_SYNC_OE} <= 4'h0;
         {KERNEL_VALID, KERNEL_DATA, KERNEL_CLOCK, KERNEL_SYNC} <= 4'h0;
      end else begin
         {RX_INTERROG_VALID_O, RX_INTERROG_DATA_O, RX_INTERROG_CLOCK_O,
            RX_INTERROG_SYNC_O} <= rec_bundle;
         {RX_INTERROG_VALID_OE, RX_INTERROG_DATA_OE, RX_INTERROG_CLOCK_OE,
            RX_INTERROG_SYNC_OE} <= {4{~central_terminal_mode}};
         {KERNEL_VALID, KERNEL_DATA, KERNEL_CLOCK, KERNEL_SYNC} <= kernel_d;
      end
   end

   // Transmitter sourcing; registering the clocks adds one cycle of skew, equal on both
   always_ff @(posedge CLK) begin
      if (RST) begin
         TX_MOD_CLOCK <= 1'b0;
         TX_DATA_CLOCK <= 1'b0;
         TX_SYNC_ENABLE <= 1'b0;
         TX_INVALIDATE_ENABLE <= 1'b0;
         TX_DATA <= 1'b0;
         TX_ENABLE <= 1'b0;
      end else begin
         TX_MOD_CLOCK <= central_terminal_mode ? CT_MODULATION_CLOCK : REC_MOD_CLOCK;
         TX_DATA_CLOCK <= central_terminal_mode ? CT_DATA_CLOCK : REC_CLOCK;
         TX_SYNC_ENABLE <= central_terminal_mode & CT_SYNC_TX_ENABLE;
         TX_INVALIDATE_ENABLE <= central_terminal_mode & CT_INVALIDATE_TX_ENABLE;
         TX_DATA <= EXT_RESPONSE_DATA | (~central_terminal_mode & KERNEL_RESPONSE_DATA);
         TX_ENABLE <= central_terminal_mode | EXT_RESPONSE_ENABLE | KERNEL_RESPONSE_ENABLE;
      end
   end

   // Selection, monitors, timeout and the combined reset
   always_ff @(posedge CLK) begin
      if (RST) begin
         KERNEL_RESPONSE_DATA_MON <= 1'b0;
         KERNEL_RESPONSE_ENABLE_MON <= 1'b0;
         TX_SELECT_NOM <= 1'b0;
         TX_SELECT_RED <= 1'b0;
         RX_ENABLE_NOM <= 1'b0;
         RX_ENABLE_RED <= 1'b0;
         BUS_TIMEOUT_N <= 1'b0;
         DEVICE_RESET_N <= 1'b0;
      end else begin
         KERNEL_RESPONSE_DATA_MON <= KERNEL_RESPONSE_DATA;
         KERNEL_RESPONSE_ENABLE_MON <= KERNEL_RESPONSE_ENABLE;
         {TX_SELECT_RED, TX_SELECT_NOM} <= tx_en_d;
         {RX_ENABLE_RED, RX_ENABLE_NOM} <= rx_en_d;
         BUS_TIMEOUT_N <= timeout_n_d;
         // Central mode keeps the watchdog out of the internal reset
         DEVICE_RESET_N <= MASTER_RESET_N & (central_terminal_mode | timeout_n_d);
      end
   end

   // Limitation: with an oscillator harmonically tied to the bus modulation some
   // edges fall outside the detection window and a live bus may time out
   assign AVS_READDATA = rdata_q;
   assign AVS_WAITREQUEST = wait_q;
endmodule : ibs_bus_select

// ===== verification/ibs_far_model.sv
// Far-side model: local oscillator, bus discriminators, recovered stream and pin drive
`timescale 1ns/1ps
module ibs_far_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic en_nom,
   input wire logic en_red,
   output logic osc,
   output logic disc_nom_n,
   output logic disc_red_n,
   output logic [4:0] rec,
   output logic [3:0] pin_drv
);
   logic [3:0] cnt_q;
   // Free-running divider; the oscillator runs free and stays far slower than the clock
   always_ff @(posedge clk) begin
      cnt_q <= rst ? 4'h0 : cnt_q + 4'h1;
   end
   assign osc = cnt_q[2];
   // Four falling edges per oscillator period on Nominal, two on Redundant; a quiet discriminator idles high
   assign disc_nom_n = en_nom ? cnt_q[0] : 1'b1;
   assign disc_red_n = en_red ? cnt_q[1] : 1'b1;
   // Recovered stream changes every cycle so stale values never pass
   assign rec = {cnt_q[0], cnt_q[1], cnt_q[2] ^ cnt_q[0], cnt_q[3], cnt_q[1] ^ cnt_q[3]};
   // Central terminal feeds the interrogation pins from its first transmitter
   assign pin_drv = cnt_q ^ 4'h5;
endmodule : ibs_far_model

// ===== verification/ibs_bus_select_monitor.sv
// Port checker for the interrogation-bus selector
`timescale 1ns/1ps
module ibs_bus_select_chk (
   input wire logic CLK,
   input wire logic RST,
   input wire logic TERMINAL_MODE_SELECT,
   input wire logic MASTER_RESET_N,
   input wire logic DUAL_BUS_TRANSMIT,
   input wire logic CT_MODULATION_CLOCK,
   input wire logic CT_SYNC_TX_ENABLE,
   input wire logic CT_INVALIDATE_TX_ENABLE,
   input wire logic REC_MOD_CLOCK,
   input wire logic REC_SYNC,
   input wire logic KERNEL_RESPONSE_DATA,
   input wire logic KERNEL_RESPONSE_ENABLE,
   input wire logic EXT_RESPONSE_DATA,
   input wire logic EXT_RESPONSE_ENABLE,
   input wire logic KERNEL_RESPONSE_DATA_MON,
   input wire logic KERNEL_RESPONSE_ENABLE_MON,
   input wire logic TX_MOD_CLOCK,
   input wire logic TX_SYNC_ENABLE,
   input wire logic TX_INVALIDATE_ENABLE,
   input wire logic TX_DATA,
   input wire logic TX_ENABLE,
   input wire logic TX_SELECT_NOM,
   input wire logic TX_SELECT_RED,
   input wire logic RX_ENABLE_NOM,
   input wire logic RX_ENABLE_RED,
   input wire logic RX_INTERROG_SYNC_O,
   input wire logic RX_INTERROG_SYNC_OE,
   input wire logic RX_INTERROG_SYNC_I,
   input wire logic KERNEL_SYNC,
   input wire logic DEVICE_RESET_N,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic AVS_WAITREQUEST
);
   // One clock domain; outputs lag their causes by exactly one cycle
   // Delayed reset keeps an attempt begun on the release edge from seeing reset values
   logic rst_seen_q;
   always_ff @(posedge CLK) begin
      rst_seen_q <= RST;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST || rst_seen_q);
   chk_rt_master_reset: assert property (!TERMINAL_MODE_SELECT && !MASTER_RESET_N |=>
      !DEVICE_RESET_N) else $error("remote reset not asserted");
   chk_ct_no_reset: assert property (TERMINAL_MODE_SELECT |=>
      DEVICE_RESET_N == $past(MASTER_RESET_N)) else $error("central reset wrong");
   chk_rt_resp_or: assert property (!TERMINAL_MODE_SELECT |=>
      TX_DATA == $past(KERNEL_RESPONSE_DATA | EXT_RESPONSE_DATA) &&
      TX_ENABLE == $past(KERNEL_RESPONSE_ENABLE | EXT_RESPONSE_ENABLE) &&
      KERNEL_RESPONSE_ENABLE_MON == $past(KERNEL_RESPONSE_ENABLE) &&
      KERNEL_RESPONSE_DATA_MON == $past(KERNEL_RESPONSE_DATA))
      else $error("response merge wrong");
   chk_ct_tx_source: assert property (TERMINAL_MODE_SELECT |=> TX_ENABLE &&
      TX_MOD_CLOCK == $past(CT_MODULATION_CLOCK) &&
      TX_INVALIDATE_ENABLE == $past(CT_INVALIDATE_TX_ENABLE) &&
      TX_SYNC_ENABLE == $past(CT_SYNC_TX_ENABLE)) else $error("central tx source wrong");
   chk_rt_tx_forced: assert property (!TERMINAL_MODE_SELECT |=>
      !TX_SYNC_ENABLE && !TX_INVALIDATE_ENABLE &&
      TX_MOD_CLOCK == $past(REC_MOD_CLOCK)) else $error("remote tx source wrong");
   chk_rt_pins_out: assert property (!TERMINAL_MODE_SELECT |=> RX_INTERROG_SYNC_OE &&
      RX_INTERROG_SYNC_O == $past(REC_SYNC) &&
      KERNEL_SYNC == $past(REC_SYNC)) else $error("remote pin routing wrong");
   chk_ct_pins_in: assert property (TERMINAL_MODE_SELECT |=> !RX_INTERROG_SYNC_OE &&
      KERNEL_SYNC == $past(RX_INTERROG_SYNC_I)) else $error("central pin routing wrong");
   chk_rx_one_set: assert property (!TERMINAL_MODE_SELECT |->
      !(RX_ENABLE_NOM && RX_ENABLE_RED)) else $error("both sets receiving");
   chk_tx_rx_set: assert property (!TERMINAL_MODE_SELECT |->
      TX_SELECT_NOM >= RX_ENABLE_NOM && TX_SELECT_RED >= RX_ENABLE_RED)
      else $error("tx set differs from rx set");
   chk_dual_both: assert property (!TERMINAL_MODE_SELECT && DUAL_BUS_TRANSMIT |=>
      TX_SELECT_NOM && TX_SELECT_RED) else $error("dual transmit not on both");
   chk_avs_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=>
      !AVS_WAITREQUEST) else $error("bus answer late");
   chk_avs_wait_back: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("wait low too long");
endmodule : ibs_bus_select_chk

bind ibs_bus_select ibs_bus_select_chk ibs_bus_select_chk_i (.*);

// ===== verification/tb.sv
// Self-checking bench for the interrogation-bus selector
`timescale 1ns/1ps
`include "ibs_cfg.svh"
module tb;
   logic CLK = 1'b0, RST = 1'b1, TERMINAL_MODE_SELECT = 1'b0, DUAL_BUS_TRANSMIT = 1'b0;
   logic MASTER_RESET_N = 1'b1, CT_BUS_SELECT = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
   logic [3:0] AVS_ADDRESS = 4'h0, AVS_BYTEENABLE = 4'hF;
   logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
   logic LOCAL_OSC_CLOCK, FALLING_DISCRIMINATOR_N_NOM, FALLING_DISCRIMINATOR_N_RED;
   logic CT_MODULATION_CLOCK, CT_DATA_CLOCK, CT_SYNC_TX_ENABLE, CT_INVALIDATE_TX_ENABLE;
   logic REC_MOD_CLOCK, REC_SYNC, REC_CLOCK, REC_DATA, REC_VALID, AVS_WAITREQUEST;
   logic KERNEL_RESPONSE_DATA, KERNEL_RESPONSE_ENABLE, EXT_RESPONSE_DATA, EXT_RESPONSE_ENABLE;
   logic RX_INTERROG_SYNC_I, RX_INTERROG_SYNC_O, RX_INTERROG_SYNC_OE, RX_INTERROG_CLOCK_I;
   logic RX_INTERROG_CLOCK_O, RX_INTERROG_CLOCK_OE, RX_INTERROG_DATA_I, RX_INTERROG_DATA_O;
   logic RX_INTERROG_DATA_OE, RX_INTERROG_VALID_I, RX_INTERROG_VALID_O, RX_INTERROG_VALID_OE;
   logic KERNEL_SYNC, KERNEL_CLOCK, KERNEL_DATA, KERNEL_VALID, KERNEL_RESPONSE_DATA_MON;
   logic KERNEL_RESPONSE_ENABLE_MON, TX_MOD_CLOCK, TX_DATA_CLOCK, TX_SYNC_ENABLE, TX_DATA;
   logic TX_INVALIDATE_ENABLE, TX_ENABLE, TX_SELECT_NOM, TX_SELECT_RED, RX_ENABLE_NOM;
   logic RX_ENABLE_RED, BUS_TIMEOUT_N, DEVICE_RESET_N, en_nom = 1'b0, en_red = 1'b0;
   logic [7:0] pat = 8'h00;
   logic [3:0] pin_drv;
   int n_mismatch = 0, total_checks = 0, n1, n2;
   wire logic [3:0] obs = {BUS_TIMEOUT_N, RX_ENABLE_RED, RX_ENABLE_NOM, DEVICE_RESET_N};

   // Pin level: the device drives when enabled, otherwise the far side does
   assign RX_INTERROG_SYNC_I = RX_INTERROG_SYNC_OE ? RX_INTERROG_SYNC_O : pin_drv[0];
   assign RX_INTERROG_CLOCK_I = RX_INTERROG_CLOCK_OE ? RX_INTERROG_CLOCK_O : pin_drv[1];
   assign RX_INTERROG_DATA_I = RX_INTERROG_DATA_OE ? RX_INTERROG_DATA_O : pin_drv[2];
   assign RX_INTERROG_VALID_I = RX_INTERROG_VALID_OE ? RX_INTERROG_VALID_O : pin_drv[3];
   // Central clocks and response streams move every cycle from one pattern counter
   assign {CT_MODULATION_CLOCK, CT_DATA_CLOCK, CT_SYNC_TX_ENABLE, CT_INVALIDATE_TX_ENABLE} =
      pat[3:0];
   assign {KERNEL_RESPONSE_DATA, KERNEL_RESPONSE_ENABLE, EXT_RESPONSE_DATA, EXT_RESPONSE_ENABLE} =
      pat[7:4] ^ pat[3:0];
   always #50 CLK = ~CLK;
   always @(posedge CLK) pat <= pat + 8'h03;

   ibs_bus_select ibs_bus_select_i (.*);
   ibs_far_model ibs_far_model_i (.clk(CLK), .rst(RST), .en_nom(en_nom), .en_red(en_red),
      .osc(LOCAL_OSC_CLOCK), .disc_nom_n(FALLING_DISCRIMINATOR_N_NOM),
      .disc_red_n(FALLING_DISCRIMINATOR_N_RED), .pin_drv(pin_drv),
      .rec({REC_MOD_CLOCK, REC_SYNC, REC_CLOCK, REC_DATA, REC_VALID}));

   task automatic tally_and_finish;
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // One bus word; held until waitrequest is seen low, a bounded wait cuts a hang
   task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata);
      int n;
      n = 0;
      @(posedge CLK);
      AVS_READ <= ~wr;
      AVS_WRITE <= wr;
      AVS_ADDRESS <= addr;
      AVS_WRITEDATA <= wdata;
      do begin
         @(posedge CLK);
         n++;
         if (n > 20) begin
            n_mismatch++;
            tally_and_finish();
         end
      end while (AVS_WAITREQUEST !== 1'b0);
      rd = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
   endtask : bus

   // Counts edges until one observed output reaches a level
   task automatic wait_obs(input int b, input logic v, input int lim, output int n);
      n = 0;
      while (obs[b] !== v) begin
         @(posedge CLK);
         n++;
         if (n > lim) begin
            n_mismatch++;
            tally_and_finish();
         end
      end
   endtask : wait_obs

   task automatic idle(input int k);
      repeat (k) @(posedge CLK);
   endtask : idle

   // Oscillator period is 8 clocks, so every window below is in oscillator cycles times 8
   initial begin
      idle(20);
      RST <= 1'b0;
      idle(2);
      chk(obs, 4'h0);
      bus(1'b0, `IBS_OFF_STATUS, 32'h0);
      chk(rd, 32'h001F1F00);
      bus(1'b0, 4'hC, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, `IBS_OFF_CTRL, 32'h1);
      bus(1'b0, `IBS_OFF_CTRL, 32'h0);
      chk(rd, 32'h1);
      chk({TX_SELECT_NOM, TX_SELECT_RED}, 2'b11);
      bus(1'b1, `IBS_OFF_CTRL, 32'h0);
      en_nom <= 1'b1;
      wait_obs(1, 1'b1, 100, n1);
      chk({BUS_TIMEOUT_N, TX_SELECT_NOM, TX_SELECT_RED, DEVICE_RESET_N}, 4'hD);
      MASTER_RESET_N <= 1'b0;
      idle(3);
      chk(DEVICE_RESET_N, 1'b0);
      MASTER_RESET_N <= 1'b1;
      en_red <= 1'b1;
      idle(200);
      chk(obs, 4'hB);
      en_nom <= 1'b0;
      wait_obs(3, 1'b0, 200, n1);
      chk(DEVICE_RESET_N, 1'b0);
      wait_obs(3, 1'b1, 20, n2);
      chk(n2, 8);
      chk(obs[2:1], 2'b10);
      chk(n1 + n2 >= 136 && n1 + n2 <= 168, 1);
      en_nom <= 1'b1;
      wait_obs(3, 1'b0, 40, n1);
      chk(n1 >= 4 && n1 <= 32, 1);
      wait_obs(3, 1'b1, 20, n2);
      chk(n2, 8);
      chk(obs[2:1], 2'b01);
      bus(1'b0, `IBS_OFF_HANDOVER, 32'h0);
      chk(rd, 32'h3);
      bus(1'b1, `IBS_OFF_HANDOVER, 32'h0);
      bus(1'b0, `IBS_OFF_HANDOVER, 32'h0);
      chk(rd, 32'h0);
      en_nom <= 1'b0;
      en_red <= 1'b0;
      wait_obs(3, 1'b0, 200, n1);
      chk(n1 >= 116 && n1 <= 156, 1);
      idle(2);
      chk(obs, 4'h0);
      idle(100);
      bus(1'b0, `IBS_OFF_STATUS, 32'h0);
      chk(rd, 32'h00101000);
      DUAL_BUS_TRANSMIT <= 1'b1;
      idle(3);
      chk({TX_SELECT_NOM, TX_SELECT_RED}, 2'b11);
      DUAL_BUS_TRANSMIT <= 1'b0;
      TERMINAL_MODE_SELECT <= 1'b1;
      CT_BUS_SELECT <= 1'b1;
      idle(3);
      chk(obs, 4'h5);
      bus(1'b0, `IBS_OFF_STATUS, 32'h0);
      chk(rd, 32'h00101020);
      CT_BUS_SELECT <= 1'b0;
      idle(3);
      chk(obs, 4'h3);
      tally_and_finish();
   end
endmodule : tb
